/* rtl/mpt_defs.svh */
// constants of the motor potentiometer reference: offsets, resets, codes, timing
`ifndef MPT_DEFS_SVH
`define MPT_DEFS_SVH

// ==========
// register byte offsets
`define MPT_OFS_MODE       8'h00
`define MPT_OFS_INIT       8'h04
`define MPT_OFS_MIN        8'h08
`define MPT_OFS_MAX        8'h0C
`define MPT_OFS_RAMP       8'h10
`define MPT_OFS_UPSEL      8'h14
`define MPT_OFS_DNSEL      8'h18
`define MPT_OFS_VALUE      8'h1C
`define MPT_OFS_STATUS     8'h20

// ==========
// reset values, values in hundredths, ramp time in tenths of a second
`define MPT_RST_MODE       2'h0
`define MPT_RST_INIT       32'sh00000000
`define MPT_RST_MIN        (-32'sd5000)
`define MPT_RST_MAX        32'sh00001388
`define MPT_RST_RAMP       16'h0190
`define MPT_RST_SEL        6'h00

// ==========
// source selector codes and field positions
`define MPT_SEL_OFF        6'h00
`define MPT_SEL_ON         6'h01
`define MPT_SEL_DI_FIRST   6'h02
`define MPT_SEL_DI_LAST    6'h07
`define MPT_SEL_TF_FIRST   6'h12
`define MPT_SEL_TF_LAST    6'h14
`define MPT_SEL_SV_FIRST   6'h18
`define MPT_SEL_SV_LAST    6'h1A
`define MPT_SEL_OTHER_BIT  5
`define MPT_ST_UP          0
`define MPT_ST_DOWN        1
`define MPT_ST_ATMIN       2
`define MPT_ST_ATMAX       3
`define MPT_ST_TRACK       4

// ==========
// timing: clock period, rate tick and ramp resolution
`define MPT_CLK_NS         10
`define MPT_TICK_NS        1000000
`define MPT_TICK_CYC       (`MPT_TICK_NS / `MPT_CLK_NS)
`define MPT_RAMP_LSB_MS    100

`endif

/* rtl/mpt_pkg.sv */
// types shared by the motor potentiometer reference
package mpt_pkg;

    // ==========================================================
    // operating modes
    typedef enum logic [1:0] {
        MPT_OFF       = 2'b00,
        MPT_INIT_STOP = 2'b01,
        MPT_RESUME    = 2'b10,
        MPT_TRACK     = 2'b11
    } mpt_mode_t;

    // ==========================================================
    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } mpt_bus_req_t;

    // ==========================================================
    // status bits that may drive a request
    typedef struct packed {
        logic [31:0] other;
        logic [2:0]  superv;
        logic [2:0]  timed;
        logic [5:0]  digIn;
    } mpt_src_t;

endpackage : mpt_pkg

/* rtl/mpt_src_sel.sv */
// request source selector of the motor potentiometer
`timescale 1ns/1ps
`include "mpt_defs.svh"

module mpt_src_sel (
    input  logic [5:0]       sel,
    input  mpt_pkg::mpt_src_t src,
    output logic             req
);
    import mpt_pkg::*;

    // ==========================================================
    // code decode, reserved codes give no request
    always_comb
    begin
        req = 1'b0;
        if (sel[`MPT_SEL_OTHER_BIT])
            req = src.other[sel[4:0]];
        else if (sel == `MPT_SEL_ON)
            req = 1'b1;
        else if (sel >= `MPT_SEL_DI_FIRST && sel <= `MPT_SEL_DI_LAST)
            req = src.digIn[3'(sel - `MPT_SEL_DI_FIRST)];
        else if (sel >= `MPT_SEL_TF_FIRST && sel <= `MPT_SEL_TF_LAST)
            req = src.timed[2'(sel - `MPT_SEL_TF_FIRST)];
        else if (sel >= `MPT_SEL_SV_FIRST && sel <= `MPT_SEL_SV_LAST)
            req = src.superv[2'(sel - `MPT_SEL_SV_FIRST)];
    end

endmodule : mpt_src_sel

/* rtl/mpt_rate_gen.sv */
// step pulse generator that sets the travel rate of the potentiometer
`timescale 1ns/1ps
`include "mpt_defs.svh"

module mpt_rate_gen #(
    parameter int unsigned TICK_CYC = `MPT_TICK_CYC
) (
    input  logic        clk,
    input  logic        rst_n,
    input  logic        active,
    input  logic [31:0] span,
    input  logic [15:0] rampTenths,
    output logic        stepPulse
);
    import mpt_pkg::*;

    logic [31:0] tickCnt_q;
    logic [31:0] acc_q;
    logic [31:0] accD;
    logic [31:0] rampTicks;
    logic        tick;
    logic        stepD;

    // ==========
    // millisecond tick
    assign tick = (tickCnt_q == TICK_CYC - 1);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tickCnt_q <= 32'h00000000;
        else if (tick)
            tickCnt_q <= 32'h00000000;
        else
            tickCnt_q <= tickCnt_q + 32'h00000001;
    end

    // ==========
    // span added per tick, one step per full ramp share
    assign rampTicks = {16'h0000, rampTenths} * 32'(`MPT_RAMP_LSB_MS);

    always_comb
    begin
        accD  = acc_q + (tick ? span : 32'h00000000);
        stepD = 1'b0;
        if (!active)
            accD = 32'h00000000;
        else if (rampTicks == 32'h00000000)
            stepD = 1'b1;                                           // zero ramp: fastest
        else if (acc_q >= rampTicks)
        begin
            accD  = accD - rampTicks;
            stepD = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q     <= 32'h00000000;
            stepPulse <= 1'b0;
        end
        else
        begin
            acc_q     <= accD;
            stepPulse <= stepD;
        end
    end

endmodule : mpt_rate_gen

/* rtl/mpt_top.sv */
// motor potentiometer reference generator with its register port
// ==========
// Overview of operation
// - init-at-stop mode loads the initial value on enable, then follows up/down
// - init-at-stop mode reloads the initial value on stop or power cycle
// - resume-always mode is like init-at-stop but keeps value over power cycle
// - init-to-actual mode tracks the other reference until the pot is selected
// - signed initial value is configurable, default zero
// - an active up request raises the value, inactive causes no rise
// - an active down request lowers the value, inactive causes no fall
// - up and down both active hold the value
// - up selector: code 0 never active, code 1 always active, default 0
// - codes 2 to 7 select digital inputs one to six
// - codes 18 to 20 select timed-function status bits 0 to 2
// - codes 24 to 26 select supervision status bits 0 to 2
// - down selector has the same codes and default as up selector
// - disabled mode forces zero output and ignores requests
// - ramp time sets minimum-to-maximum travel, same both ways, default 40 s
// - minimum and maximum bounds configurable, default -50 and +50
`timescale 1ns/1ps
`include "mpt_defs.svh"

module mpt_top #(
    parameter int unsigned TICK_CYC = `MPT_TICK_CYC
) (
    input  logic                 clk,
    input  logic                 rst_n,
    input  mpt_pkg::mpt_bus_req_t busReq,
    output logic [31:0]          rdata_q,
    input  logic [5:0]           digIn,
    input  logic [2:0]           timedStatus,
    input  logic [2:0]           supervStatus,
    input  logic [31:0]          otherBits,
    input  logic                 driveRun,
    input  logic                 powerRestart,
    input  logic                 potSelected,
    input  logic signed [31:0]   otherRef,
    output logic signed [31:0]   potValue_q,
    output logic                 potAtMin_q,
    output logic                 potAtMax_q
);
    import mpt_pkg::*;

    // ==========
    // declarations
    mpt_mode_t          mode_q;
    mpt_mode_t          prevMode_q;
    logic signed [31:0] initVal_q;
    logic signed [31:0] minVal_q;
    logic signed [31:0] maxVal_q;
    logic [15:0]        rampTenths_q;
    logic [5:0]         upSel_q;
    logic [5:0]         downSel_q;
    logic [5:0]         digMeta_q;
    logic [5:0]         digSync_q;
    logic               runPrev_q;
    logic               tracking_q;
    logic               upReq;
    logic               downReq;
    logic               stepPulse;
    logic               rateActive;
    logic               modeEnter;
    logic               stopEvent;
    logic               tracking;
    logic [31:0]        span;
    logic signed [31:0] valueD;
    logic signed [31:0] bumped;
    logic [31:0]        readMux;
    mpt_src_t           srcBits;

    // ==========
    // helpers
    // saturate a value into [lo, hi]
    function automatic logic signed [31:0] clampVal(
        input logic signed [31:0] v,
        input logic signed [31:0] lo,
        input logic signed [31:0] hi
    );
        logic signed [31:0] r;
        r = v;
        if (v > hi)
            r = hi;
        if (v < lo)
            r = lo;
        return r;
    endfunction : clampVal

    // ==========
    // register writes
    // configuration registers written from the register port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q       <= MPT_OFF;
            initVal_q    <= `MPT_RST_INIT;
            minVal_q     <= `MPT_RST_MIN;
            maxVal_q     <= `MPT_RST_MAX;
            rampTenths_q <= `MPT_RST_RAMP;
            upSel_q      <= `MPT_RST_SEL;
            downSel_q    <= `MPT_RST_SEL;
        end
        else if (busReq.we)
        begin
            case (busReq.addr)
                `MPT_OFS_MODE:  mode_q       <= mpt_mode_t'(busReq.wdata[1:0]);
                `MPT_OFS_INIT:  initVal_q    <= busReq.wdata;
                `MPT_OFS_MIN:   minVal_q     <= busReq.wdata;
                `MPT_OFS_MAX:   maxVal_q     <= busReq.wdata;
                `MPT_OFS_RAMP:  rampTenths_q <= busReq.wdata[15:0];
                `MPT_OFS_UPSEL: upSel_q      <= busReq.wdata[5:0];
                `MPT_OFS_DNSEL: downSel_q    <= busReq.wdata[5:0];
                default:        mode_q       <= mode_q;             // unmapped: ignored
            endcase
        end
    end

    // ==========
    // register reads
    // read mux, unmapped offsets read zero
    always_comb
    begin
        readMux = 32'h00000000;
        case (busReq.addr)
            `MPT_OFS_MODE:   readMux = {30'h00000000, mode_q};
            `MPT_OFS_INIT:   readMux = initVal_q;
            `MPT_OFS_MIN:    readMux = minVal_q;
            `MPT_OFS_MAX:    readMux = maxVal_q;
            `MPT_OFS_RAMP:   readMux = {16'h0000, rampTenths_q};
            `MPT_OFS_UPSEL:  readMux = {26'h0000000, upSel_q};
            `MPT_OFS_DNSEL:  readMux = {26'h0000000, downSel_q};
            `MPT_OFS_VALUE:  readMux = potValue_q;
            `MPT_OFS_STATUS:
            begin
                readMux[`MPT_ST_UP]    = upReq;
                readMux[`MPT_ST_DOWN]  = downReq;
                readMux[`MPT_ST_ATMIN] = potAtMin_q;
                readMux[`MPT_ST_ATMAX] = potAtMax_q;
                readMux[`MPT_ST_TRACK] = tracking_q;
            end
            default:         readMux = 32'h00000000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 32'h00000000;
        else if (busReq.re)
            rdata_q <= readMux;
        else
            rdata_q <= 32'h00000000;
    end

    // ==========
    // input conditioning
    // digital input pins pass two flip-flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            digMeta_q <= 6'h00;
            digSync_q <= 6'h00;
        end
        else
        begin
            digMeta_q <= digIn;
            digSync_q <= digMeta_q;
        end
    end

    // status bits offered to both selectors
    assign srcBits.digIn  = digSync_q;
    assign srcBits.timed  = timedStatus;
    assign srcBits.superv = supervStatus;
    assign srcBits.other  = otherBits;

    // ==========
    // request selectors
    mpt_src_sel u_upSel (
        .sel (upSel_q),
        .src (srcBits),
        .req (upReq)
    );

    // down selector shares the same code table
    mpt_src_sel u_downSel (
        .sel (downSel_q),
        .src (srcBits),
        .req (downReq)
    );

    // ==========
    // event detection
    // history of mode and run state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevMode_q <= MPT_OFF;
            runPrev_q  <= 1'b0;
            tracking_q <= 1'b0;
        end
        else
        begin
            prevMode_q <= mode_q;
            runPrev_q  <= driveRun;
            tracking_q <= tracking;
        end
    end

    // enable or change of mode, stop as falling run level
    assign modeEnter = (mode_q != MPT_OFF) && (prevMode_q != mode_q);
    assign stopEvent = runPrev_q && !driveRun;
    assign tracking  = (mode_q == MPT_TRACK) && !potSelected;

    // ==========
    // travel rate
    // span of the travel range, zero if bounds are crossed
    assign span = (maxVal_q > minVal_q) ? 32'(maxVal_q - minVal_q) : 32'h00000000;

    // rate runs only while exactly one request moves the value
    assign rateActive = (mode_q != MPT_OFF) && !tracking && (upReq != downReq)
                        && !(upReq && potAtMax_q) && !(downReq && potAtMin_q);

    mpt_rate_gen #(
        .TICK_CYC (TICK_CYC)
    ) u_rate (
        .clk        (clk),
        .rst_n      (rst_n),
        .active     (rateActive),
        .span       (span),
        .rampTenths (rampTenths_q),
        .stepPulse  (stepPulse)
    );

    // ==========
    // value update
    // one step up or down, both requests hold
    always_comb
    begin
        bumped = potValue_q;
        if (stepPulse && upReq && !downReq)
            bumped = potValue_q + 32'sd1;
        else if (stepPulse && downReq && !upReq)
            bumped = potValue_q - 32'sd1;
        else
            bumped = potValue_q;
    end

    // mode priority: track, enter, stop, restart, step
    always_comb
    begin
        valueD = clampVal(bumped, minVal_q, maxVal_q);
        case (mode_q)
            MPT_OFF:
                valueD = 32'sh00000000;
            MPT_INIT_STOP:
            begin
                if (modeEnter)
                    valueD = clampVal(initVal_q, minVal_q, maxVal_q);
                else if (stopEvent || powerRestart)
                    valueD = clampVal(initVal_q, minVal_q, maxVal_q);
            end
            MPT_RESUME:
            begin
                if (modeEnter || stopEvent)
                    valueD = clampVal(initVal_q, minVal_q, maxVal_q);
            end
            MPT_TRACK:
            begin
                if (tracking)
                    valueD = clampVal(otherRef, minVal_q, maxVal_q);
                else if (modeEnter)
                    valueD = clampVal(initVal_q, minVal_q, maxVal_q);
            end
            default:
                valueD = 32'sh00000000;
        endcase
    end

    // value and limit flags registered together
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            potValue_q <= 32'sh00000000;
            potAtMin_q <= 1'b0;
            potAtMax_q <= 1'b0;
        end
        else
        begin
            potValue_q <= valueD;
            potAtMin_q <= (mode_q != MPT_OFF) && (valueD <= minVal_q);
            potAtMax_q <= (mode_q != MPT_OFF) && (valueD >= maxVal_q);
        end
    end

endmodule : mpt_top

/* verification/mpt_src_model.sv */
// partner model: digital inputs and status words that feed the request selectors
`timescale 1ns/1ps

module mpt_src_model (
    input  logic [3:0]  srcIdx,
    input  logic        srcOn,
    output logic [5:0]  digIn,
    output logic [2:0]  timedStatus,
    output logic [2:0]  supervStatus,
    output logic [31:0] otherBits
);
    logic [11:0] hot;
    // ==========
    // one source high: 0..5 inputs, 6..8 timed, 9..11 supervision, 13 all of them
    assign hot = !srcOn ? 12'h000 : ((srcIdx == 4'hD) ? 12'hFFF : 12'h001 << srcIdx);
    assign digIn = hot[5:0];
    assign timedStatus = hot[8:6];
    assign supervStatus = hot[11:9];
    assign otherBits = {32{hot[0] & hot[11]}};
endmodule : mpt_src_model

/* verification/mpt_props.sv */
// assertion checker of the motor potentiometer reference
`timescale 1ns/1ps
`include "mpt_defs.svh"

module mpt_props #(
    parameter int unsigned TICK_CYC = `MPT_TICK_CYC
) (
    input logic                  clk,
    input logic                  rst_n,
    input mpt_pkg::mpt_bus_req_t busReq,
    input logic                  driveRun,
    input logic                  powerRestart,
    input logic                  potSelected,
    input logic signed [31:0]    otherRef,
    input logic signed [31:0]    potValue_q,
    input logic                  potAtMax_q
);
    import mpt_pkg::*;
    logic [1:0]         mode_q;
    logic signed [31:0] init_q, min_q, max_q;
    logic [5:0]         up_q, dn_q;
    logic [2:0]         quiet_q;
    logic               run_q, quiet, moving, modeWr;

    function automatic logic signed [31:0] clampV(input logic signed [31:0] v);
        return (v < min_q || min_q > max_q) ? min_q : ((v > max_q) ? max_q : v);
    endfunction : clampV

    // ==========
    // copy of the configuration, ramp time excepted, as written over the port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= `MPT_RST_MODE;
            init_q <= `MPT_RST_INIT;
            min_q  <= `MPT_RST_MIN;
            max_q  <= `MPT_RST_MAX;
            up_q   <= `MPT_RST_SEL;
            dn_q   <= `MPT_RST_SEL;
        end
        else if (busReq.we)
        begin
            case (busReq.addr)
                `MPT_OFS_MODE:  mode_q <= busReq.wdata[1:0];
                `MPT_OFS_INIT:  init_q <= busReq.wdata;
                `MPT_OFS_MIN:   min_q <= busReq.wdata;
                `MPT_OFS_MAX:   max_q <= busReq.wdata;
                `MPT_OFS_UPSEL: up_q <= busReq.wdata[5:0];
                `MPT_OFS_DNSEL: dn_q <= busReq.wdata[5:0];
                default: ;
            endcase
        end
    end

    // cycles since the last write, run change or restart, so pipelines have settled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quiet_q <= 3'h0;
            run_q   <= 1'b0;
        end
        else
        begin
            run_q <= driveRun;
            if (busReq.we || powerRestart || driveRun != run_q)
                quiet_q <= 3'h0;
            else if (quiet_q != 3'h7)
                quiet_q <= quiet_q + 3'h1;
        end
    end

    assign quiet = quiet_q >= 3'h5;
    assign moving = mode_q == 2'h1 || mode_q == 2'h2;
    assign modeWr = busReq.we && busReq.addr == `MPT_OFS_MODE && busReq.wdata[1:0] != mode_q
                    && (busReq.wdata[1:0] == 2'h1 || busReq.wdata[1:0] == 2'h2);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_off_zero: assert property (mode_q == 2'h0 && $past(mode_q) == 2'h0 |-> potValue_q == 0)
        else $error("value not zero while disabled");
    chk_load_init: assert property (modeWr |-> ##[1:3] potValue_q == clampV(init_q))
        else $error("initial value not loaded on enable");
    chk_stop_reload: assert property ((moving && $fell(driveRun)) || (mode_q == 2'h1 && powerRestart)
        |-> ##[1:3] potValue_q == clampV(init_q)) else $error("no reload on stop or restart");
    chk_resume_keep: assert property (mode_q == 2'h2 && powerRestart && quiet && up_q == dn_q
        |=> $stable(potValue_q)[*2]) else $error("value lost over restart");
    chk_track_ref: assert property (mode_q == 2'h3 && !potSelected && quiet && $stable(otherRef)
        |-> ##[1:3] potValue_q == clampV(otherRef)) else $error("value not tracking");
    chk_up_rise: assert property (quiet && moving && up_q == 6'h01 && dn_q == 6'h00
        |-> potValue_q >= $past(potValue_q)) else $error("value fell on up request");
    chk_down_fall: assert property (quiet && moving && dn_q == 6'h01 && up_q == 6'h00
        |-> potValue_q <= $past(potValue_q)) else $error("value rose on down request");
    chk_both_hold: assert property (quiet && moving && up_q == dn_q |-> $stable(potValue_q))
        else $error("value moved with equal requests");
    chk_reserved_idle: assert property (quiet && moving && dn_q == 6'h00 && up_q inside {[6'h08:6'h11]}
        |-> $stable(potValue_q)) else $error("reserved code moved value");
    chk_within_bounds: assert property (quiet && mode_q != 2'h0
        |-> potValue_q >= min_q && potValue_q <= max_q) else $error("value outside bounds");

    cover property (mode_q == 2'h3 && !potSelected && quiet);
    cover property (moving && $fell(driveRun));
    cover property (potAtMax_q && quiet);
endmodule : mpt_props

bind mpt_top mpt_props #(.TICK_CYC(TICK_CYC)) u_props (.clk(clk), .rst_n(rst_n), .busReq(busReq),
    .driveRun(driveRun), .powerRestart(powerRestart), .potSelected(potSelected),
    .otherRef(otherRef), .potValue_q(potValue_q), .potAtMax_q(potAtMax_q));

/* verification/mpt_tb.sv */
// self-checking testbench of the motor potentiometer reference
`timescale 1ns/1ps
`include "mpt_defs.svh"

module tb;
    import mpt_pkg::*;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    mpt_bus_req_t       busReq = '0;
    logic [31:0]        rdata_q, otherBits, v0, v1;
    logic [5:0]         digIn;
    logic [2:0]         timedStatus, supervStatus;
    logic               driveRun = 1'b1;
    logic               powerRestart = 1'b0;
    logic               potSelected = 1'b1;
    logic signed [31:0] otherRef = '0;
    logic signed [31:0] potValue_q;
    logic               potAtMin_q, potAtMax_q, srcOn = 1'b0;
    logic [3:0]         srcIdx = 4'h0;
    logic [5:0]         codeTab [12] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
                                         6'h12, 6'h13, 6'h14, 6'h18, 6'h19, 6'h1A};
    logic [5:0]         idleTab [6] = '{6'h00, 6'h08, 6'h11, 6'h15, 6'h17, 6'h1B};
    int                 fails = 0;
    int                 cmp_count = 0;

    always #5 clk = ~clk;

    mpt_top #(.TICK_CYC(10)) dut_u (.clk(clk), .rst_n(rst_n), .busReq(busReq), .rdata_q(rdata_q),
        .digIn(digIn), .timedStatus(timedStatus), .supervStatus(supervStatus),
        .otherBits(otherBits), .driveRun(driveRun), .powerRestart(powerRestart),
        .potSelected(potSelected), .otherRef(otherRef), .potValue_q(potValue_q),
        .potAtMin_q(potAtMin_q), .potAtMax_q(potAtMax_q));
    mpt_src_model src_u (.srcIdx(srcIdx), .srcOn(srcOn), .digIn(digIn),
        .timedStatus(timedStatus), .supervStatus(supervStatus), .otherBits(otherBits));

    // ==========
    // access tasks and comparison
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq.addr  <= a;
        busReq.wdata <= d;
        busReq.we    <= 1'b1;
        @(posedge clk);
        busReq.we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        busReq.addr <= a;
        busReq.re   <= 1'b1;
        @(posedge clk);
        busReq.re <= 1'b0;
        #1 d = rdata_q;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, exp);
    endtask : rdchk

    task automatic pulse_restart();
        @(posedge clk);
        powerRestart <= 1'b1;
        @(posedge clk);
        powerRestart <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : pulse_restart

    // select a source, raise it for a while and see whether the value moved
    task automatic try_sel(input logic [7:0] ofs, input logic [5:0] code,
                           input logic [3:0] idx, input logic expMove);
        logic [31:0] a, b;
        logic        ok;
        wr(ofs, {26'h0, code});
        rd(`MPT_OFS_VALUE, a);
        @(posedge clk);
        srcIdx <= idx;
        srcOn  <= 1'b1;
        repeat (40) @(posedge clk);
        srcOn <= 1'b0;
        repeat (8) @(posedge clk);
        rd(`MPT_OFS_VALUE, b);
        wr(ofs, 32'h0);
        ok = !expMove ? a == b : (ofs == `MPT_OFS_UPSEL ? $signed(b) > $signed(a) : $signed(b) < $signed(a));
        check({31'h0, ok}, 32'h1);
    endtask : try_sel

    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // watchdog against a hang
    initial
    begin
        #200000;
        fails++;
        report_and_stop();
    end

    // ==========
    // test sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`MPT_OFS_MODE, 32'h0);
        rdchk(`MPT_OFS_INIT, 32'h0);
        rdchk(`MPT_OFS_MIN, 32'hFFFFEC78);
        rdchk(`MPT_OFS_MAX, 32'h00001388);
        rdchk(`MPT_OFS_RAMP, 32'h00000190);
        rdchk(`MPT_OFS_UPSEL, 32'h0);
        rdchk(`MPT_OFS_DNSEL, 32'h0);
        rdchk(8'h40, 32'h0);
        check(potValue_q, 32'h0);
        $display("test reset finished");
        wr(`MPT_OFS_MIN, 32'h0);
        wr(`MPT_OFS_MAX, 32'h64);
        wr(`MPT_OFS_RAMP, 32'h1);
        wr(`MPT_OFS_INIT, 32'h32);
        wr(`MPT_OFS_MODE, 32'h1);
        repeat (4) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h32);
        wr(`MPT_OFS_UPSEL, 32'h1);
        repeat (250) @(posedge clk);
        rd(`MPT_OFS_VALUE, v0);
        check({31'h0, $signed(v0) >= 32'sh48 && $signed(v0) <= 32'sh4E}, 32'h1);
        wr(`MPT_OFS_DNSEL, 32'h1);
        repeat (10) @(posedge clk);
        rd(`MPT_OFS_VALUE, v0);
        repeat (100) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, v0);
        wr(`MPT_OFS_UPSEL, 32'h0);
        repeat (250) @(posedge clk);
        rd(`MPT_OFS_VALUE, v1);
        v1 = v0 - v1;
        check({31'h0, $signed(v1) >= 32'sh16 && $signed(v1) <= 32'sh1C}, 32'h1);
        wr(`MPT_OFS_DNSEL, 32'h0);
        wr(`MPT_OFS_UPSEL, 32'h1);
        repeat (1100) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h64);
        check({31'h0, potAtMax_q}, 32'h1);
        rdchk(`MPT_OFS_STATUS, 32'h9);
        wr(`MPT_OFS_UPSEL, 32'h0);
        wr(`MPT_OFS_DNSEL, 32'h1);
        repeat (1100) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h0);
        check({31'h0, potAtMin_q}, 32'h1);
        rdchk(`MPT_OFS_STATUS, 32'h6);
        wr(`MPT_OFS_DNSEL, 32'h0);
        $display("test ramp finished");
        pulse_restart();
        rdchk(`MPT_OFS_VALUE, 32'h32);
        for (int i = 0; i < 12; i++)
        begin
            try_sel(`MPT_OFS_UPSEL, codeTab[i], 4'(i), 1'b1);
            try_sel(`MPT_OFS_DNSEL, codeTab[i], 4'(i), 1'b1);
        end
        for (int i = 0; i < 6; i++)
            try_sel(`MPT_OFS_UPSEL, idleTab[i], 4'hD, 1'b0);
        $display("test selectors finished");
        wr(`MPT_OFS_UPSEL, 32'h1);
        repeat (50) @(posedge clk);
        wr(`MPT_OFS_UPSEL, 32'h0);
        @(posedge clk);
        driveRun <= 1'b0;
        repeat (5) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h32);
        driveRun <= 1'b1;
        wr(`MPT_OFS_MODE, 32'h2);
        wr(`MPT_OFS_UPSEL, 32'h1);
        repeat (50) @(posedge clk);
        wr(`MPT_OFS_UPSEL, 32'h0);
        repeat (6) @(posedge clk);
        rd(`MPT_OFS_VALUE, v0);
        repeat (6) @(posedge clk);
        pulse_restart();
        rdchk(`MPT_OFS_VALUE, v0);
        @(posedge clk);
        driveRun <= 1'b0;
        repeat (5) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h32);
        driveRun    <= 1'b1;
        potSelected <= 1'b0;
        otherRef    <= 32'sh25;
        wr(`MPT_OFS_MODE, 32'h3);
        repeat (6) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h25);
        otherRef <= 32'sh1F4;
        repeat (4) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h64);
        rdchk(`MPT_OFS_STATUS, 32'h18);
        otherRef <= 32'sh14;
        repeat (4) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h14);
        potSelected <= 1'b1;
        wr(`MPT_OFS_UPSEL, 32'h1);
        repeat (50) @(posedge clk);
        wr(`MPT_OFS_UPSEL, 32'h0);
        rd(`MPT_OFS_VALUE, v0);
        check({31'h0, $signed(v0) >= 32'sh15 && $signed(v0) <= 32'sh1C}, 32'h1);
        $display("test modes finished");
        wr(`MPT_OFS_UPSEL, 32'h1);
        wr(`MPT_OFS_MODE, 32'h0);
        repeat (40) @(posedge clk);
        rdchk(`MPT_OFS_VALUE, 32'h0);
        check(potValue_q, 32'h0);
        $display("test disable finished");
        report_and_stop();
    end
endmodule : tb
